/* hdl/tdp_dma.sv */
// Purpose: Transmit descriptor DMA path: fetch, data DMA, store-and-forward FIFO, MAC, write-back
// Assumes: Host keeps ring setup, descriptors and tail pointer one request outstanding
// Notes: A packet must fit in 512 words; data moves in whole 32-bit words
//
// Behaviour
// - Tail change triggers descriptor fetch reads
// - Completions stored in descriptor cache slot
// - Decode cached descriptor, request its buffer
// - Offloads applied on the fly
// - MAC starts only after whole packet stored
// - MAC appends frame CRC on transmit
// - Descriptor done only after last completion
// - Posted write-back on threshold or timer
// - Optional head-pointer-only write-back
// - Timer expiry raises completion interrupt
// - Three transmit timestamp modes
// - Exactly five interrupt vectors
// - Low-power idle only copper 100/1000
`timescale 1ns/1ns
`default_nettype none
module tdp_dma (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic queue_en_i,
   input wire logic [31:0] ring_base_i,
   input wire logic [15:0] ring_len_i,
   input wire logic [15:0] head_init_i,
   input wire logic [15:0] tx_queue_tail_pointer_i,
   input wire logic [15:0] wb_thresh_i,
   input wire logic head_wb_en_i,
   input wire logic [31:0] head_wb_addr_i,
   input wire logic [15:0] itr_interval_i,
   input wire logic [2:0] irq_vector_i,
   input wire logic [1:0] ts_mode_i,
   input wire logic eee_en_i,
   input wire logic phy_internal_copper_i,
   input wire logic [1:0] link_speed_i,
   input wire logic rd_ready_i,
   input wire logic cpl_valid_i,
   input wire logic [31:0] cpl_data_i,
   input wire logic cpl_last_i,
   input wire logic wr_ready_i,
   input wire logic tx_ready_i,
   output logic rd_req_o,
   output logic [31:0] rd_addr_o,
   output logic [15:0] rd_len_o,
   output logic wr_valid_o,
   output logic [31:0] wr_addr_o,
   output logic [31:0] wr_data_o,
   output logic tx_valid_o,
   output logic [31:0] tx_data_o,
   output logic tx_last_o,
   output logic [4:0] msix_o,
   output logic lpi_req_o,
   output logic [15:0] head_o,
   output logic [31:0] ts_latched_o
);
   typedef struct packed {
      tdp_pkg::tdp_dma_e dma;
      tdp_pkg::tdp_mac_e mac;
      logic [15:0] tail;
      logic [15:0] head;
      logic [15:0] fetch;
      logic [15:0] wbp;
      logic [3:0] ncache;
      logic [15:0] pend;
      logic rd_req;
      logic [31:0] rd_addr;
      logic [15:0] rd_len;
      logic cword;
      logic [31:0] cdesc_lo;
      logic cwe;
      logic [2:0] cwaddr;
      logic [63:0] cwdata;
      logic [63:0] desc;
      logic [15:0] csum;
      logic fwe;
      logic [8:0] fwaddr;
      logic [31:0] fwdata;
      logic [9:0] pkt_words;
      logic pkt_ready;
      logic [9:0] fifo_rd;
      logic tx_valid;
      logic [31:0] tx_data;
      logic tx_last;
      logic [31:0] crc;
      logic [31:0] time_cnt;
      logic [31:0] ts;
      logic [31:0] ts_latched;
      logic [19:0] itr_cnt;
      logic itr_run;
      logic itr_fire;
      logic wr_valid;
      logic [31:0] wr_addr;
      logic [31:0] wr_data;
      logic [4:0] msix;
      logic lpi;
   } tdp_state_s;

   localparam tdp_state_s S_RST = '0;

   tdp_state_s s_q;
   tdp_state_s s_d;
   logic [63:0] cache_rdata;
   logic [31:0] fifo_rdata;
   logic desc_done;
   logic flush;

   // Next ring index, wrapping at the programmed length
   function automatic logic [15:0] ring_next(input logic [15:0] p, input logic [15:0] len);
      logic [15:0] n;
      n = p + 16'h0001;
      return (n >= len) ? 16'h0000 : n;
   endfunction : ring_next

   // Ones-complement 16-bit add with end-around carry
   function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[15:0] + {15'h0000, s[16]};
   endfunction : oc_add

   // Reflected CRC-32 over one word, low bit first
   function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 32; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ tdp_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_word

   // Descriptor cache, indexed by low ring index bits
   tdp_ram #(.AW(tdp_pkg::CACHE_AW), .DW(tdp_pkg::DESC_W)) u_cache (
      .clk_i(clk_i),
      .we_i(s_q.cwe),
      .waddr_i(s_q.cwaddr),
      .wdata_i(s_q.cwdata),
      .raddr_i(s_q.head[2:0]),
      .rdata_o(cache_rdata)
   );

   // Transmit FIFO holding one whole packet
   tdp_ram #(.AW(tdp_pkg::FIFO_AW), .DW(32)) u_fifo (
      .clk_i(clk_i),
      .we_i(s_q.fwe),
      .waddr_i(s_q.fwaddr),
      .wdata_i(s_q.fwdata),
      .raddr_i(s_q.fifo_rd[8:0]),
      .rdata_o(fifo_rdata)
   );

   // Next-state logic of both the DMA and the MAC side
   always_comb begin
      s_d = s_q;
      desc_done = 1'b0;
      flush = 1'b0;
      s_d.time_cnt = s_q.time_cnt + 32'h00000001;
      s_d.cwe = 1'b0;
      s_d.fwe = 1'b0;
      s_d.msix = 5'h00;
      s_d.tail = queue_en_i ? tx_queue_tail_pointer_i : head_init_i;
      if (s_q.rd_req && rd_ready_i) begin
         s_d.rd_req = 1'b0;
      end
      case (s_q.dma)
         tdp_pkg::D_IDLE: begin
            if (!queue_en_i) begin
               flush = 1'b1;
               s_d.head = head_init_i;
               s_d.fetch = head_init_i;
               s_d.wbp = head_init_i;
               s_d.pend = 16'h0000;
            end else if (s_q.itr_fire || (wb_thresh_i != 16'h0000 && s_q.pend >= wb_thresh_i)) begin
               s_d.dma = tdp_pkg::D_WB;
            end else if (s_q.fetch != s_q.tail && s_q.ncache < 4'(tdp_pkg::CACHE_DEPTH)) begin
               // Fetch one descriptor; only slots between head and tail are read
               s_d.rd_req = 1'b1;
               s_d.rd_addr = ring_base_i + (32'(s_q.fetch) << tdp_pkg::DESC_SHIFT);
               s_d.rd_len = tdp_pkg::DESC_FETCH_LEN;
               s_d.cword = 1'b0;
               s_d.dma = tdp_pkg::D_DWAIT;
            end else if (s_q.ncache != 4'h0 && !s_q.pkt_ready && s_q.mac == tdp_pkg::M_IDLE) begin
               s_d.dma = tdp_pkg::D_PREP;
            end
         end
         tdp_pkg::D_DWAIT: begin
            if (cpl_valid_i) begin
               if (!s_q.cword) begin
                  s_d.cdesc_lo = cpl_data_i;
                  s_d.cword = 1'b1;
               end else begin
                  s_d.cwe = 1'b1;
                  s_d.cwaddr = s_q.fetch[2:0];
                  s_d.cwdata = {cpl_data_i, s_q.cdesc_lo};
                  s_d.fetch = ring_next(s_q.fetch, ring_len_i);
                  s_d.dma = tdp_pkg::D_IDLE;
               end
            end
         end
         tdp_pkg::D_PREP: begin
            // Decode the cached descriptor and ask for its buffer
            s_d.desc = cache_rdata;
            s_d.rd_req = 1'b1;
            s_d.rd_addr = cache_rdata[31:0];
            s_d.rd_len = cache_rdata[tdp_pkg::DESC_LEN_LSB +: 16];
            s_d.dma = tdp_pkg::D_XWAIT;
         end
         tdp_pkg::D_XWAIT: begin
            if (cpl_valid_i) begin
               s_d.fwe = 1'b1;
               s_d.fwaddr = s_q.pkt_words[8:0];
               s_d.fwdata = cpl_data_i;
               s_d.pkt_words = s_q.pkt_words + 10'h001;
               if (s_q.desc[tdp_pkg::DESC_CSUM_BIT]) begin
                  s_d.csum = oc_add(oc_add(s_q.csum, cpl_data_i[31:16]), cpl_data_i[15:0]);
               end
               if (cpl_last_i) begin
                  // Descriptor is finished only with its last completion
                  desc_done = 1'b1;
                  s_d.head = ring_next(s_q.head, ring_len_i);
                  s_d.pend = s_q.pend + 16'h0001;
                  if (s_q.desc[tdp_pkg::DESC_EOP_BIT]) begin
                     s_d.ts = s_q.time_cnt;
                     if (s_q.desc[tdp_pkg::DESC_TS_BIT] && ts_mode_i == tdp_pkg::TS_IN_REG) begin
                        s_d.ts_latched = s_q.time_cnt;
                     end
                     s_d.dma = s_q.desc[tdp_pkg::DESC_CSUM_BIT] ? tdp_pkg::D_CSUM : tdp_pkg::D_TS;
                  end else begin
                     s_d.dma = tdp_pkg::D_IDLE;
                  end
               end
            end
         end
         tdp_pkg::D_CSUM: begin
            // Checksum word follows the data, inserted without a second pass
            s_d.fwe = 1'b1;
            s_d.fwaddr = s_q.pkt_words[8:0];
            s_d.fwdata = {16'h0000, ~s_q.csum};
            s_d.pkt_words = s_q.pkt_words + 10'h001;
            s_d.dma = tdp_pkg::D_TS;
         end
         tdp_pkg::D_TS: begin
            if (s_q.desc[tdp_pkg::DESC_TS_BIT] && ts_mode_i == tdp_pkg::TS_IN_PKT) begin
               s_d.fwe = 1'b1;
               s_d.fwaddr = s_q.pkt_words[8:0];
               s_d.fwdata = s_q.ts;
               s_d.pkt_words = s_q.pkt_words + 10'h001;
            end
            s_d.pkt_ready = 1'b1;
            s_d.csum = 16'h0000;
            s_d.dma = tdp_pkg::D_IDLE;
         end
         tdp_pkg::D_WB: begin
            if (s_q.wr_valid) begin
               if (wr_ready_i) begin
                  s_d.wr_valid = 1'b0;
                  if (!head_wb_en_i) begin
                     s_d.wbp = ring_next(s_q.wbp, ring_len_i);
                     s_d.pend = s_q.pend - 16'h0001;
                  end
               end
            end else if (s_q.wbp == s_q.head) begin
               // Interrupt only after everything is written back
               if (s_q.itr_fire) begin
                  s_d.itr_fire = 1'b0;
                  s_d.msix[(irq_vector_i > tdp_pkg::MSIX_LAST) ? 3'h0 : irq_vector_i] = 1'b1;
               end
               s_d.dma = tdp_pkg::D_IDLE;
            end else if (head_wb_en_i) begin
               s_d.wr_valid = 1'b1;
               s_d.wr_addr = head_wb_addr_i;
               s_d.wr_data = {16'h0000, s_q.head};
               s_d.wbp = s_q.head;
               s_d.pend = 16'h0000;
            end else begin
               s_d.wr_valid = 1'b1;
               s_d.wr_addr = ring_base_i + (32'(s_q.wbp) << tdp_pkg::DESC_SHIFT) + tdp_pkg::DESC_STATUS_OFS;
               s_d.wr_data = tdp_pkg::STAT_DD | ((ts_mode_i == tdp_pkg::TS_IN_DESC) ? {s_q.ts[31:1], 1'b0} : 32'h0);
            end
         end
         default: begin
            s_d.dma = tdp_pkg::D_IDLE;
         end
      endcase
      // Cache fill counts once the memory holds the word, so a read never sees stale data
      if (flush) begin
         s_d.ncache = 4'h0;
      end else begin
         s_d.ncache = s_q.ncache + {3'h0, s_q.cwe} - {3'h0, desc_done};
      end
      // Moderation timer starts with the first pending descriptor
      if (s_q.itr_run) begin
         s_d.itr_cnt = s_q.itr_cnt - 20'h00001;
         if (s_q.itr_cnt <= 20'h00001) begin
            s_d.itr_run = 1'b0;
            s_d.itr_fire = 1'b1;
         end
      end else if (s_q.pend != 16'h0000 && !s_q.itr_fire) begin
         s_d.itr_run = 1'b1;
         s_d.itr_cnt = 20'(itr_interval_i * tdp_pkg::ITR_UNIT_CYC);
      end
      // MAC drains the FIFO only for a complete packet
      case (s_q.mac)
         tdp_pkg::M_IDLE: begin
            if (s_q.pkt_ready) begin
               s_d.fifo_rd = 10'h000;
               s_d.crc = tdp_pkg::CRC_INIT;
               s_d.mac = tdp_pkg::M_RD;
            end
         end
         tdp_pkg::M_RD: begin
            s_d.mac = tdp_pkg::M_LOAD;
         end
         tdp_pkg::M_LOAD: begin
            s_d.tx_valid = 1'b1;
            s_d.tx_data = fifo_rdata;
            s_d.crc = crc_word(s_q.crc, fifo_rdata);
            s_d.fifo_rd = s_q.fifo_rd + 10'h001;
            s_d.mac = tdp_pkg::M_SEND;
         end
         tdp_pkg::M_SEND: begin
            if (tx_ready_i) begin
               if (s_q.fifo_rd == s_q.pkt_words) begin
                  s_d.tx_data = ~s_q.crc;
                  s_d.tx_last = 1'b1;
                  s_d.mac = tdp_pkg::M_CRC;
               end else begin
                  s_d.tx_valid = 1'b0;
                  s_d.mac = tdp_pkg::M_RD;
               end
            end
         end
         tdp_pkg::M_CRC: begin
            if (tx_ready_i) begin
               s_d.tx_valid = 1'b0;
               s_d.tx_last = 1'b0;
               s_d.pkt_ready = 1'b0;
               s_d.pkt_words = 10'h000;
               s_d.mac = tdp_pkg::M_IDLE;
            end
         end
         default: begin
            s_d.mac = tdp_pkg::M_IDLE;
         end
      endcase
      // Low-power idle only when allowed by the PHY and the path is empty
      s_d.lpi = eee_en_i && phy_internal_copper_i
         && (link_speed_i == tdp_pkg::SPEED_100 || link_speed_i == tdp_pkg::SPEED_1000)
         && s_q.dma == tdp_pkg::D_IDLE && s_q.mac == tdp_pkg::M_IDLE && !s_q.pkt_ready
         && s_q.fetch == s_q.tail && s_q.ncache == 4'h0;
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= S_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign rd_req_o = s_q.rd_req;
   assign rd_addr_o = s_q.rd_addr;
   assign rd_len_o = s_q.rd_len;
   assign wr_valid_o = s_q.wr_valid;
   assign wr_addr_o = s_q.wr_addr;
   assign wr_data_o = s_q.wr_data;
   assign tx_valid_o = s_q.tx_valid;
   assign tx_data_o = s_q.tx_data;
   assign tx_last_o = s_q.tx_last;
   assign msix_o = s_q.msix;
   assign lpi_req_o = s_q.lpi;
   assign head_o = s_q.head;
   assign ts_latched_o = s_q.ts_latched;

   // Checks
   a_fetch_on_tail: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_q.dma == tdp_pkg::D_IDLE && queue_en_i && s_q.fetch != s_q.tail && s_q.ncache == 4'h0
       && !s_q.itr_fire && wb_thresh_i == 16'h0000) |=> rd_req_o && s_q.dma == tdp_pkg::D_DWAIT)
      else $error("tail change did not start a descriptor fetch");
   a_cache_fill: assert property (@(posedge clk_i) disable iff (rst_i)
      (s_q.dma == tdp_pkg::D_DWAIT && cpl_valid_i && s_q.cword) |=> s_q.cwe ##1 ($past(s_q.cwe) && s_q.ncache != 4'h0))
      else $error("descriptor completion not stored in cache");
   a_data_request: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.dma == tdp_pkg::D_PREP |=> rd_req_o && rd_addr_o == $past(cache_rdata[31:0]))
      else $error("buffer read does not follow the cached descriptor");
   a_store_forward: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_valid_o |-> s_q.pkt_ready && s_q.dma != tdp_pkg::D_XWAIT)
      else $error("transmit started before packet fully stored");
   a_crc_last: assert property (@(posedge clk_i) disable iff (rst_i)
      (tx_valid_o && tx_last_o) |-> s_q.mac == tdp_pkg::M_CRC && s_q.fifo_rd == s_q.pkt_words)
      else $error("frame ended without the CRC word");
   a_head_after_cpl: assert property (@(posedge clk_i) disable iff (rst_i)
      (queue_en_i && $past(queue_en_i) && $changed(s_q.head)) |-> $past(cpl_valid_i) && $past(cpl_last_i))
      else $error("head advanced without the last completion");
   a_wb_state: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_valid_o |-> (s_q.dma == tdp_pkg::D_WB) and (!wr_ready_i |=> wr_valid_o && $stable(wr_addr_o)))
      else $error("write-back outside write-back state or dropped");
   a_irq_after_wb: assert property (@(posedge clk_i) disable iff (rst_i)
      (msix_o != 5'h00) |-> !wr_valid_o && s_q.wbp == s_q.head && !s_q.itr_fire)
      else $error("interrupt raised before write-back finished");
   a_msix_count: assert property (@(posedge clk_i) disable iff (rst_i)
      $onehot0(msix_o) && msix_o[4:0] == msix_o)
      else $error("more than one vector or vector out of range");
   a_lpi_mode: assert property (@(posedge clk_i) disable iff (rst_i)
      lpi_req_o |-> $past(phy_internal_copper_i) && ($past(link_speed_i) == tdp_pkg::SPEED_100
                                                     || $past(link_speed_i) == tdp_pkg::SPEED_1000))
      else $error("low-power idle outside copper 100/1000");
   a_ring_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
      (queue_en_i && $stable(ring_len_i) && $past(s_q.head) < ring_len_i && $changed(s_q.head))
      |-> s_q.head < ring_len_i)
      else $error("head pointer passed the ring length");
endmodule : tdp_dma
`default_nettype wire

/* hdl/tdp_pkg.sv */
// Purpose: Shared constants and state types of the transmit descriptor DMA path
// Assumes: One transmit queue, 32-bit completions, 10 MHz core clock
// Notes: Descriptor layout and timing figures live here only
package tdp_pkg;
   // Widths and depths
   localparam int PTR_W = 16;
   localparam int CACHE_AW = 3;
   localparam int CACHE_DEPTH = 8;
   localparam int FIFO_AW = 9;
   localparam int DESC_W = 64;
   localparam int DESC_SHIFT = 4;
   // Descriptor fields
   localparam int DESC_LEN_LSB = 32;
   localparam int DESC_EOP_BIT = 48;
   localparam int DESC_CSUM_BIT = 49;
   localparam int DESC_TS_BIT = 50;
   localparam logic [31:0] DESC_STATUS_OFS = 32'h0000000C;
   localparam logic [31:0] STAT_DD = 32'h00000001;
   localparam logic [15:0] DESC_FETCH_LEN = 16'h0008;
   // Timestamp modes
   localparam logic [1:0] TS_IN_DESC = 2'h0;
   localparam logic [1:0] TS_IN_PKT = 2'h1;
   localparam logic [1:0] TS_IN_REG = 2'h2;
   // Link speed codes
   localparam logic [1:0] SPEED_100 = 2'h1;
   localparam logic [1:0] SPEED_1000 = 2'h2;
   // Interrupt vectors
   localparam int MSIX_VECTORS = 5;
   localparam logic [2:0] MSIX_LAST = 3'h4;
   // Moderation timer: interval is given in microseconds
   localparam int CLK_PERIOD_NS = 100;
   localparam int ITR_UNIT_NS = 1000;
   localparam int ITR_UNIT_CYC = (ITR_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Frame check sequence
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
   localparam logic [31:0] CRC_POLY = 32'hEDB88320;
   // States
   typedef enum logic [3:0] {D_IDLE, D_DWAIT, D_PREP, D_XWAIT, D_CSUM, D_TS, D_WB} tdp_dma_e;
   typedef enum logic [2:0] {M_IDLE, M_RD, M_LOAD, M_SEND, M_CRC} tdp_mac_e;
endpackage : tdp_pkg

/* hdl/tdp_ram.sv */
// Purpose: Simple dual-port memory with registered read data
// Assumes: Write and read on the same clock
// Notes: Read of a word written on the same edge returns the old word
`timescale 1ns/1ns
`default_nettype none
module tdp_ram #(
   parameter int AW = 3,
   parameter int DW = 64
) (
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [DW-1:0] wdata_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [DW-1:0] rdata_o
);
   logic [DW-1:0] mem_q [2**AW];

   // Storage has no reset; contents are only read after being written
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_q[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_q[raddr_i];
   end
endmodule : tdp_ram
`default_nettype wire

/* verif/tb.sv */
// Purpose: Self-checking bench for the transmit descriptor DMA path
// Assumes: Ring of four descriptors at a fixed base; one packet in flight
// Notes: Monitors log line words and interrupts; tests judge them
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam logic [31:0] BASE = 32'h00001000;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic queue_en_i = 1'b0;
   logic [31:0] ring_base_i = BASE;
   logic [15:0] ring_len_i = 16'h0004;
   logic [15:0] head_init_i = 16'h0000;
   logic [15:0] tx_queue_tail_pointer_i = 16'h0000;
   logic [15:0] wb_thresh_i = 16'h0001;
   logic head_wb_en_i = 1'b0;
   logic [31:0] head_wb_addr_i = 32'h00008000;
   logic [15:0] itr_interval_i = 16'h0002;
   logic [2:0] irq_vector_i = 3'h3;
   logic [1:0] ts_mode_i = tdp_pkg::TS_IN_DESC;
   logic eee_en_i = 1'b0;
   logic phy_internal_copper_i = 1'b0;
   logic [1:0] link_speed_i = 2'h0;
   logic tx_ready_i = 1'b1;
   logic rd_ready_i, cpl_valid_i, cpl_last_i, wr_ready_i, busy;
   logic rd_req_o, wr_valid_o, tx_valid_o, tx_last_o, lpi_req_o;
   logic [31:0] cpl_data_i, rd_addr_o, wr_addr_o, wr_data_o, tx_data_o, ts_latched_o;
   logic [15:0] rd_len_o, head_o;
   logic [4:0] msix_o;
   logic [4:0] irq_seen = 5'h00;
   logic stall = 1'b0;
   int irq_cycles = 0;
   int n_mismatch = 0;
   int tests_run = 0;
   int last_at = 0;
   logic [31:0] txq [$];
   tdp_dma dut_u (.clk_i, .rst_i, .queue_en_i, .ring_base_i, .ring_len_i, .head_init_i,
      .tx_queue_tail_pointer_i, .wb_thresh_i, .head_wb_en_i, .head_wb_addr_i, .itr_interval_i,
      .irq_vector_i, .ts_mode_i, .eee_en_i, .phy_internal_copper_i, .link_speed_i, .rd_ready_i,
      .cpl_valid_i, .cpl_data_i, .cpl_last_i, .wr_ready_i, .tx_ready_i, .rd_req_o, .rd_addr_o,
      .rd_len_o, .wr_valid_o, .wr_addr_o, .wr_data_o, .tx_valid_o, .tx_data_o, .tx_last_o,
      .msix_o, .lpi_req_o, .head_o, .ts_latched_o);
   tdp_host_model mem_u (.clk_i, .rst_i, .rd_req_i(rd_req_o), .rd_addr_i(rd_addr_o),
      .rd_len_i(rd_len_o), .wr_valid_i(wr_valid_o), .wr_addr_i(wr_addr_o), .wr_data_i(wr_data_o),
      .rd_ready_o(rd_ready_i), .cpl_valid_o(cpl_valid_i), .cpl_data_o(cpl_data_i),
      .cpl_last_o(cpl_last_i), .wr_ready_o(wr_ready_i), .busy_o(busy));
   always #50 clk_i = ~clk_i;
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : wrap_up
   // Monitors; line words and write-backs only after all reads
   always @(posedge clk_i) begin
      if (tx_valid_o && tx_ready_i) begin
         txq.push_back(tx_data_o);
         last_at = tx_last_o ? txq.size() : 0;
         check("tx_after_fetch", {31'h0, busy}, 32'h0);
      end
      if (wr_valid_o && wr_ready_i) check("wb_after_cpl", {31'h0, busy}, 32'h0);
      if (msix_o !== 5'h00) begin
         irq_seen <= msix_o;
         irq_cycles++;
      end
      tx_ready_i <= stall ? ~tx_ready_i : 1'b1;
   end
   // Waits for frame and write-back, then a quiet spell
   task automatic settle(input int ntx);
      int i;
      for (i = 0; i < 3000 && (txq.size() < ntx || mem_u.wq_addr.size() == 0); i++) @(posedge clk_i);
      if (i == 3000) begin
         n_mismatch++;
         $display("ERROR timeout expected %0d words seen %0d", ntx, txq.size());
         wrap_up();
      end
      repeat (40) @(posedge clk_i);
   endtask : settle
   task automatic run_pkt(input int slot, input int nw, input logic [2:0] fl, input int extra);
      logic [31:0] bf, c, s, w;
      int k, b;
      bf = 32'h00020000 + 32'(slot) * 32'h00000100;
      mem_u.mem[BASE + 32'(16 * slot)] = bf;
      mem_u.mem[BASE + 32'(16 * slot + 4)] = {13'h0000, fl, 16'(4 * nw)};
      s = 32'h0;
      for (k = 0; k < nw; k++) begin
         w = {16'hC3A5 ^ 16'(k), bf[15:0] + 16'(k)};
         mem_u.mem[bf + 32'(4 * k)] = w;
         s = s + {16'h0, w[15:0]} + {16'h0, w[31:16]};
      end
      txq.delete();
      mem_u.rq_addr.delete();
      mem_u.wq_addr.delete();
      mem_u.wq_data.delete();
      irq_cycles = 0;
      @(posedge clk_i);
      irq_seen <= 5'h00;
      tx_queue_tail_pointer_i <= 16'((slot + 1) % 4);
      settle(nw + extra + 1);
      check("desc_addr", mem_u.rq_addr[0], BASE + 32'(16 * slot));
      check("data_addr", mem_u.rq_addr[1], bf);
      check("tx_count", 32'(txq.size()), 32'(nw + extra + 1));
      for (k = 0; k < nw; k++) check("tx_word", txq[k], mem_u.mem[bf + 32'(4 * k)]);
      c = tdp_pkg::CRC_INIT;
      for (k = 0; k < txq.size() - 1; k++)
         for (b = 0; b < 32; b++) c = (c >> 1) ^ ((c[0] ^ txq[k][b]) ? tdp_pkg::CRC_POLY : 32'h0);
      check("fcs", txq[txq.size() - 1], ~c);
      check("tx_last", 32'(last_at), 32'(nw + extra + 1));
      s = {16'h0, s[15:0]} + {16'h0, s[31:16]};
      s = {16'h0, s[15:0]} + {16'h0, s[31:16]};
      if (fl[1]) check("csum", txq[nw], {16'h0, ~s[15:0]});
      check("head", {16'h0, head_o}, 32'((slot + 1) % 4));
   endtask : run_pkt
   task automatic t_lpi();
      logic [4:0] tbl [5] = '{5'h1B, 5'h1D, 5'h14, 5'h1E, 5'h0C};
      int i;
      for (i = 0; i < 5; i++) begin
         @(posedge clk_i);
         {eee_en_i, phy_internal_copper_i, link_speed_i} <= tbl[i][4:1];
         repeat (4) @(posedge clk_i);
         check("lpi_req", {31'h0, lpi_req_o}, {31'h0, tbl[i][0]});
      end
      $display("test lpi done");
   endtask : t_lpi
   task automatic t_basic();
      run_pkt(0, 2, 3'h1, 0);
      check("wb_addr", mem_u.wq_addr[0], BASE + tdp_pkg::DESC_STATUS_OFS);
      check("wb_done", {31'h0, mem_u.wq_data[0][0]}, 32'h1);
      $display("test basic done");
   endtask : t_basic
   task automatic t_csum();
      stall = 1'b1;
      mem_u.slow = 3;
      run_pkt(1, 3, 3'h3, 1);
      stall = 1'b0;
      mem_u.slow = 0;
      $display("test csum done");
   endtask : t_csum
   task automatic t_ts();
      logic [31:0] prev;
      @(posedge clk_i);
      ts_mode_i <= tdp_pkg::TS_IN_PKT;
      run_pkt(2, 2, 3'h5, 1);
      @(posedge clk_i);
      ts_mode_i <= tdp_pkg::TS_IN_REG;
      prev = ts_latched_o;
      run_pkt(3, 2, 3'h5, 0);
      check("ts_latch", {31'h0, ts_latched_o !== prev}, 32'h1);
      $display("test ts done");
   endtask : t_ts
   task automatic t_head();
      @(posedge clk_i);
      head_wb_en_i <= 1'b1;
      run_pkt(0, 1, 3'h1, 0);
      check("hwb_addr", mem_u.wq_addr[0], head_wb_addr_i);
      check("hwb_data", mem_u.wq_data[0], 32'h00000001);
      @(posedge clk_i);
      head_wb_en_i <= 1'b0;
      $display("test head done");
   endtask : t_head
   task automatic t_irq();
      int i;
      for (i = 0; i < 2; i++) begin
         @(posedge clk_i);
         wb_thresh_i <= 16'h0000;
         itr_interval_i <= 16'h0002;
         irq_vector_i <= (i == 0) ? 3'h3 : 3'h7;
         run_pkt(1 + i, 1, 3'h1, 0);
         check("irq_vec", {27'h0, irq_seen}, (i == 0) ? 32'h00000008 : 32'h00000001);
         check("irq_len", 32'(irq_cycles), 32'h1);
         check("tmr_wb", {31'h0, mem_u.wq_data[0][0]}, 32'h1);
      end
      $display("test irq done");
   endtask : t_irq
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      check("reset_outs", {rd_req_o, wr_valid_o, tx_valid_o, msix_o, head_o}, 32'h0);
      @(posedge clk_i);
      queue_en_i <= 1'b1;
      t_lpi();
      t_basic();
      t_csum();
      t_ts();
      t_head();
      t_irq();
      wrap_up();
   end
endmodule : tb
`default_nettype wire

/* verif/tdp_host_model.sv */
// Purpose: Host memory and PCIe far side of the transmit DMA path
// Assumes: One read outstanding; completion words one per cycle or slower
// Notes: Idle completion data toggles so a stale word never looks valid
`timescale 1ns/1ns
`default_nettype none
module tdp_host_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic rd_req_i,
   input wire logic [31:0] rd_addr_i,
   input wire logic [15:0] rd_len_i,
   input wire logic wr_valid_i,
   input wire logic [31:0] wr_addr_i,
   input wire logic [31:0] wr_data_i,
   output logic rd_ready_o,
   output logic cpl_valid_o,
   output logic [31:0] cpl_data_o,
   output logic cpl_last_o,
   output logic wr_ready_o,
   output logic busy_o
);
   logic [31:0] mem [logic [31:0]];
   logic [31:0] rq_addr [$];
   logic [31:0] wq_addr [$];
   logic [31:0] wq_data [$];
   logic [31:0] a = 32'h0;
   int n = 0;
   int gap = 0;
   int slow = 0;
   initial {rd_ready_o, cpl_valid_o, cpl_data_o, cpl_last_o, wr_ready_o, busy_o} = '0;
   // Ring and buffers live in mem; a request is taken, then streamed, slower when slow is set
   always @(posedge clk_i) begin
      rd_ready_o <= 1'b0;
      wr_ready_o <= 1'b0;
      cpl_valid_o <= 1'b0;
      cpl_last_o <= 1'b0;
      cpl_data_o <= ~cpl_data_o;
      if (rst_i) begin
         n = 0;
         busy_o <= 1'b0;
      end else if (rd_req_i && rd_ready_o) begin
         a = rd_addr_i;
         n = (int'(rd_len_i) + 3) / 4;
         gap = slow;
         busy_o <= 1'b1;
         rq_addr.push_back(rd_addr_i);
      end else if (rd_req_i && n == 0) begin
         rd_ready_o <= 1'b1;
      end else if (n > 0 && gap > 0) begin
         gap--;
      end else if (n > 0) begin
         cpl_valid_o <= 1'b1;
         cpl_data_o <= mem.exists(a) ? mem[a] : ~a;
         cpl_last_o <= (n == 1);
         busy_o <= (n > 1);
         a += 4;
         n--;
         gap = slow;
      end
      if (wr_valid_i && wr_ready_o) begin
         wq_addr.push_back(wr_addr_i);
         wq_data.push_back(wr_data_i);
      end else if (wr_valid_i) begin
         wr_ready_o <= 1'b1;
      end
   end
endmodule : tdp_host_model
`default_nettype wire
